// File: src/flash_self_program_sequencer.sv
// Row erase / row program sequencer for on-chip program flash
`default_nettype none
module flash_self_program_sequencer #(
	parameter int unsigned OP_CYCLES = nvm_pkg::OP_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic warm_reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire nvm_pkg::tbl_req_t tbl_req,
	output nvm_pkg::tbl_rsp_t tbl_rsp,
	output nvm_pkg::array_cmd_t array_cmd,
	input wire logic [23:0] array_rd_data,
	output logic cpu_stall
);
	import nvm_pkg::*;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_t;
	typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} op_t;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_ofs;
		logic start;
		logic gate;
		logic err;
		logic twri;
		logic [6:0] opsel;
		logic [15:0] addr_low;
		logic [7:0] addr_up;
		key_t key;
		op_t op;
		logic [CNT_W-1:0] cnt;
		logic [4:0] idx;
		logic done_flag;
		logic stall;
		logic tbl_active;
		logic tbl_high;
		logic tbl_byte;
		logic tbl_bsel;
		tbl_rsp_t rsp;
		array_cmd_t arr;
	} state_t;

	localparam state_t S_RST = '{hreadyout: 1'b1, key: KEY_IDLE,
		op: ST_IDLE, addr_low: ADDR_LOW_RST, addr_up: ADDR_UP_RST,
		default: '0};

	state_t s_r;
	state_t s_nxt;
	latch_wr_t lw;
	logic [23:0] lat_word;
	logic addr_ok;
	logic accept;
	logic busy;

	write_latch_bank u_latches (
		.clk(clk),
		.reset(reset),
		.wr(lw),
		.rd_idx(s_r.idx),
		.rd_word(lat_word)
	);

	assign busy = s_r.start;

	always_comb begin
		s_nxt = s_r;
		s_nxt.arr.erase = 1'b0;
		s_nxt.arr.prog_we = 1'b0;
		s_nxt.rsp.done = 1'b0;
		lw = '0;

		// Bus address phase; reads are answered from a flop next cycle
		addr_ok = hsel && htrans[1] && hready;
		s_nxt.wr_pend = addr_ok && hwrite;
		s_nxt.wr_ofs = haddr[7:0];
		s_nxt.hrdata = '0;
		if (addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				OFS_CONTROL: s_nxt.hrdata = {16'h0000, s_r.start, s_r.gate,
					s_r.err, 4'h0, s_r.twri, 1'b0, s_r.opsel};
				OFS_ADDR_LOW: s_nxt.hrdata = {16'h0000, s_r.addr_low};
				OFS_ADDR_UP: s_nxt.hrdata = {24'h00_0000, s_r.addr_up};
				OFS_STATUS: s_nxt.hrdata = {30'h0000_0000, busy, s_r.done_flag};
				default: s_nxt.hrdata = '0; // Key reads as zero
			endcase
		end

		// Bus data phase write
		if (s_r.wr_pend) begin
			s_nxt.key = KEY_IDLE;
			if (s_r.wr_ofs == OFS_KEY) begin
				if (hwdata[7:0] == KEY_FIRST)
					s_nxt.key = KEY_HALF;
				else if (s_r.key == KEY_HALF && hwdata[7:0] == KEY_SECOND)
					s_nxt.key = KEY_ARMED;
			end else if (s_r.wr_ofs == OFS_CONTROL && !busy) begin
				s_nxt.gate = hwdata[CTL_GATE_BIT];
				s_nxt.err = hwdata[CTL_ERR_BIT];
				s_nxt.twri = hwdata[CTL_TWRI_BIT];
				s_nxt.opsel = hwdata[CTL_OPSEL_MSB:0];
				// Start only on the write right after the key pair
				if (hwdata[CTL_START_BIT] && s_r.key == KEY_ARMED
					&& hwdata[CTL_GATE_BIT]
					&& (hwdata[CTL_OPSEL_MSB:0] == OP_ROW_ERASE
					|| hwdata[CTL_OPSEL_MSB:0] == OP_ROW_PROG)) begin
					s_nxt.start = 1'b1;
					s_nxt.stall = 1'b1;
					s_nxt.cnt = CNT_W'(OP_CYCLES);
					s_nxt.idx = '0;
					if (hwdata[CTL_OPSEL_MSB:0] == OP_ROW_ERASE) begin
						s_nxt.arr.erase = 1'b1;
						s_nxt.arr.addr = {s_r.addr_up,
							s_r.addr_low[15:ROW_ADDR_BITS],
							ROW_ADDR_BITS'(0)};
						s_nxt.op = ST_WAIT;
					end else begin
						s_nxt.op = ST_STREAM;
					end
				end
			end else if (s_r.wr_ofs == OFS_ADDR_LOW && !busy) begin
				s_nxt.addr_low = hwdata[15:0];
			end else if (s_r.wr_ofs == OFS_ADDR_UP && !busy) begin
				s_nxt.addr_up = hwdata[7:0];
			end else if (s_r.wr_ofs == OFS_STATUS && hwdata[STS_DONE_BIT]) begin
				s_nxt.done_flag = 1'b0;
			end
		end

		// Running operation; the latch row streams out first when programming
		if (s_r.op != ST_IDLE) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
			if (s_r.op == ST_STREAM) begin
				s_nxt.arr.prog_we = 1'b1;
				s_nxt.arr.addr = {s_r.addr_up, s_r.addr_low[15:ROW_ADDR_BITS],
					s_r.idx, 1'b0};
				s_nxt.arr.data = lat_word;
				s_nxt.idx = s_r.idx + 1'b1;
				if (s_r.idx == 5'(ROW_WORDS - 1))
					s_nxt.op = ST_WAIT;
			end
			if (s_r.cnt == CNT_W'(1)) begin
				s_nxt.op = ST_IDLE;
				s_nxt.start = 1'b0;
				s_nxt.stall = 1'b0;
				s_nxt.done_flag = 1'b1;
			end
		end

		// Table accesses; held off while an operation runs
		accept = tbl_req.valid && !s_r.tbl_active && !s_r.rsp.done
			&& s_r.op == ST_IDLE && !s_r.start;
		if (accept) begin
			s_nxt.tbl_active = 1'b1;
			s_nxt.addr_low = tbl_req.ea;
			s_nxt.addr_up = tbl_req.page;
			s_nxt.arr.rd_addr = {tbl_req.page, tbl_req.ea};
			s_nxt.tbl_high = tbl_req.high;
			s_nxt.tbl_byte = tbl_req.byte_mode;
			s_nxt.tbl_bsel = tbl_req.ea[0];
			lw.we = tbl_req.write;
			lw.high = tbl_req.high;
			lw.byte_mode = tbl_req.byte_mode;
			lw.byte_sel = tbl_req.ea[0];
			lw.idx = tbl_req.ea[5:1];
			lw.data = tbl_req.wdata;
		end
		if (s_r.tbl_active) begin
			s_nxt.tbl_active = 1'b0;
			s_nxt.rsp.done = 1'b1;
			if (s_r.tbl_high)
				s_nxt.rsp.rdata = (s_r.tbl_byte && s_r.tbl_bsel) ? 16'h0000
					: {8'h00, array_rd_data[23:16]};
			else if (s_r.tbl_byte)
				s_nxt.rsp.rdata = {8'h00, s_r.tbl_bsel ? array_rd_data[15:8]
					: array_rd_data[7:0]};
			else
				s_nxt.rsp.rdata = array_rd_data[15:0];
		end

		// Warm reset aborts the operation but leaves the address alone
		if (warm_reset) begin
			if (s_r.start)
				s_nxt.err = 1'b1;
			s_nxt.start = 1'b0;
			s_nxt.stall = 1'b0;
			s_nxt.op = ST_IDLE;
			s_nxt.cnt = '0;
			s_nxt.key = KEY_IDLE;
			s_nxt.tbl_active = 1'b0;
			s_nxt.rsp.done = 1'b0;
			s_nxt.arr.erase = 1'b0;
			s_nxt.arr.prog_we = 1'b0;
			lw.we = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			s_r <= S_RST;
		else
			s_r <= s_nxt;
	end

	assign hreadyout = s_r.hreadyout;
	assign hresp = s_r.hresp;
	assign hrdata = s_r.hrdata;
	assign tbl_rsp = s_r.rsp;
	assign array_cmd = s_r.arr;
	assign cpu_stall = s_r.stall;

	// Helper counters for the checks below
	logic [CNT_W-1:0] busy_len;
	logic [5:0] prog_words;
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_len <= '0;
			prog_words <= '0;
		end else begin
			busy_len <= s_r.start ? busy_len + 1'b1 : '0;
			prog_words <= s_r.start ? prog_words + 6'(s_r.arr.prog_we) : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_start_keyed;
		$rose(s_r.start) |-> $past(s_r.key) == KEY_ARMED;
	endproperty
	a_start_keyed: assert property (p_start_keyed)
		else $error("start launched without key pair");

	property p_gate;
		$rose(s_r.start) |-> s_r.gate;
	endproperty
	a_gate: assert property (p_gate)
		else $error("start launched with write gate clear");

	property p_duration;
		$fell(s_r.start) && !$past(warm_reset) |->
			busy_len == CNT_W'(OP_CYCLES) && s_r.done_flag;
	endproperty
	a_duration: assert property (p_duration)
		else $error("operation length or done flag wrong");

	property p_no_sw_clear;
		s_r.start && !warm_reset && s_r.cnt != CNT_W'(1) |=> s_r.start;
	endproperty
	a_no_sw_clear: assert property (p_no_sw_clear)
		else $error("start bit dropped early");

	property p_erase_pulse;
		$rose(s_r.start) && s_r.opsel == OP_ROW_ERASE |->
			s_r.arr.erase && s_r.arr.addr[5:0] == 6'h00 ##1 !s_r.arr.erase;
	endproperty
	a_erase_pulse: assert property (p_erase_pulse)
		else $error("row erase not a single aligned pulse");

	property p_prog_words;
		$fell(s_r.start) && !$past(warm_reset) && s_r.opsel == OP_ROW_PROG
			|-> prog_words == 6'd32;
	endproperty
	a_prog_words: assert property (p_prog_words)
		else $error("program did not write 32 words");

	property p_table_idle;
		s_r.start |-> !lw.we && !s_nxt.tbl_active;
	endproperty
	a_table_idle: assert property (p_table_idle)
		else $error("table access taken during operation");

	property p_table_timing;
		accept && !warm_reset |=> s_r.addr_low == $past(tbl_req.ea)
			&& s_r.addr_up == $past(tbl_req.page) ##1 s_r.rsp.done;
	endproperty
	a_table_timing: assert property (p_table_timing)
		else $error("table access capture or two-cycle answer wrong");

	property p_abort_err;
		warm_reset && s_r.start |=> s_r.err && !s_r.start
			&& $stable(s_r.addr_low);
	endproperty
	a_abort_err: assert property (p_abort_err)
		else $error("aborted operation lost error or address");

	c_erase: cover property ($fell(s_r.start) && s_r.opsel == OP_ROW_ERASE);
	c_prog: cover property ($fell(s_r.start) && s_r.opsel == OP_ROW_PROG);
	c_tbl_write: cover property (accept && tbl_req.write);
	c_disarm: cover property (s_r.key == KEY_HALF ##1 s_r.key == KEY_IDLE);
endmodule
`default_nettype wire

// File: src/nvm_pkg.sv
// Shared constants and carrier types for the flash self-program sequencer
`default_nettype none
package nvm_pkg;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned OP_TIME_NS = 2_000_000;
	localparam int unsigned OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 18;

	// Array geometry
	localparam int unsigned ROW_WORDS = 32;
	localparam int unsigned PANEL_ROWS = 128;
	localparam int unsigned ROW_ADDR_BITS = 6;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
	localparam logic [7:0] OFS_ADDR_UP = 8'h08;
	localparam logic [7:0] OFS_KEY = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Control register fields
	localparam int unsigned CTL_START_BIT = 15;
	localparam int unsigned CTL_GATE_BIT = 14;
	localparam int unsigned CTL_ERR_BIT = 13;
	localparam int unsigned CTL_TWRI_BIT = 8;
	localparam int unsigned CTL_OPSEL_MSB = 6;
	// Status register fields
	localparam int unsigned STS_DONE_BIT = 0;
	localparam int unsigned STS_BUSY_BIT = 1;

	// Operation selections and unlock keys
	localparam logic [6:0] OP_ROW_ERASE = 7'h41;
	localparam logic [6:0] OP_ROW_PROG = 7'h01;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// Reset values
	localparam logic [15:0] ADDR_LOW_RST = 16'h0000;
	localparam logic [7:0] ADDR_UP_RST = 8'h00;
	localparam logic [23:0] LATCH_RST = 24'h00_0000;

	typedef struct packed {
		logic valid;
		logic write;
		logic high;
		logic byte_mode;
		logic [7:0] page;
		logic [15:0] ea;
		logic [15:0] wdata;
	} tbl_req_t;

	typedef struct packed {
		logic done;
		logic [15:0] rdata;
	} tbl_rsp_t;

	typedef struct packed {
		logic erase;
		logic prog_we;
		logic [23:0] addr;
		logic [23:0] data;
		logic [23:0] rd_addr;
	} array_cmd_t;

	typedef struct packed {
		logic we;
		logic high;
		logic byte_mode;
		logic byte_sel;
		logic [4:0] idx;
		logic [15:0] data;
	} latch_wr_t;
endpackage
`default_nettype wire

// File: src/write_latch_bank.sv
// Row of program write latches filled by table stores
`default_nettype none
module write_latch_bank (
	input wire logic clk,
	input wire logic reset,
	input wire nvm_pkg::latch_wr_t wr,
	input wire logic [4:0] rd_idx,
	output logic [23:0] rd_word
);
	import nvm_pkg::*;

	typedef struct packed {
		logic [ROW_WORDS-1:0][23:0] mem;
	} lstate_t;

	lstate_t s_r;
	lstate_t s_nxt;
	logic [23:0] ent_nxt [ROW_WORDS];

	for (genvar g = 0; g < ROW_WORDS; g++) begin : g_entry
		always_comb begin
			ent_nxt[g] = s_r.mem[g];
			if (wr.we && wr.idx == 5'(g)) begin
				if (!wr.high) begin
					if (!wr.byte_mode)
						ent_nxt[g][15:0] = wr.data;
					else if (wr.byte_sel)
						ent_nxt[g][15:8] = wr.data[7:0];
					else
						ent_nxt[g][7:0] = wr.data[7:0];
				end else if (!(wr.byte_mode && wr.byte_sel)) begin
					// Odd byte of the high word has no storage behind it
					ent_nxt[g][23:16] = wr.data[7:0];
				end
			end
		end
	end

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < ROW_WORDS; i++) begin
			s_nxt.mem[i] = ent_nxt[i];
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			s_r <= {ROW_WORDS{LATCH_RST}};
		else
			s_r <= s_nxt;
	end

	assign rd_word = s_r.mem[rd_idx];
endmodule
`default_nettype wire

// File: testbench/core_model.sv
// Processor-side model: table instructions and a flash array image
`default_nettype none
module core_model (
	input wire logic clk,
	output var nvm_pkg::tbl_req_t tbl_req,
	input wire nvm_pkg::tbl_rsp_t tbl_rsp,
	input wire nvm_pkg::array_cmd_t array_cmd,
	output logic [23:0] array_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import nvm_pkg::*;

	initial tbl_req = '0;

	// Each array word derives from its address, so a wrong address shows
	assign array_rd_data = array_cmd.rd_addr ^ 24'hC3_5A96;

	// One table instruction; the request stands until done is sampled
	task automatic access(input logic wr, input logic hi, input logic bm,
		input logic [7:0] pg, input logic [15:0] ea, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok);
		tbl_req_t t;
		int n;
		t = '0;
		t.valid = 1'b1;
		t.write = wr;
		t.high = hi;
		t.byte_mode = bm;
		t.page = pg;
		t.ea = ea;
		t.wdata = wd;
		@(posedge clk);
		tbl_req <= t;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tbl_rsp.done !== 1'b1 && n < 400);
		ok = (n < 400);
		rd = tbl_rsp.rdata;
		// Released fields must not look valid, so show the inverse
		t = ~t;
		t.valid = 1'b0;
		tbl_req <= t;
	endtask
endmodule
`default_nettype wire

// File: testbench/test_flash_self_program_sequencer.sv
// Self-checking bench for the flash self-program sequencer
`default_nettype none
module test_flash_self_program_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import nvm_pkg::*;
	localparam int unsigned OPC = 64;
	logic clk = 0, reset = 1, warm_reset = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'b010;
	logic hreadyout, hresp, cpu_stall, ok, bm = 1'b0;
	tbl_req_t tbl_req;
	tbl_rsp_t tbl_rsp;
	array_cmd_t array_cmd;
	logic [23:0] array_rd_data, exp_row, x;
	logic [23:0] lat [32];
	logic [15:0] base, rd, ea;
	logic [7:0] pg;
	logic [7:0] offs [6] = '{OFS_CONTROL, OFS_ADDR_LOW, OFS_ADDR_UP,
		OFS_KEY, OFS_STATUS, 8'h14};
	int seed = 50656;
	int mismatches = 0, num_checks = 0, nstall = 0, nprog = 0, nerase = 0;

	always #5 clk = ~clk;

	flash_self_program_sequencer #(.OP_CYCLES(OPC))
		i_flash_self_program_sequencer (
		.clk(clk), .reset(reset), .warm_reset(warm_reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .tbl_req(tbl_req), .tbl_rsp(tbl_rsp),
		.array_cmd(array_cmd), .array_rd_data(array_rd_data),
		.cpu_stall(cpu_stall));

	core_model i_core_model (.clk(clk), .tbl_req(tbl_req), .tbl_rsp(tbl_rsp),
		.array_cmd(array_cmd), .array_rd_data(array_rd_data));

	task automatic fail(input string m);
		mismatches++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e,
		input string m);
		num_checks++;
		if (g !== e) fail(m);
	endtask

	function automatic logic [23:0] img(input logic [23:0] a);
		return a ^ 24'hC3_5A96;
	endfunction

	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail("bus timeout");
			wrap_up();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		rdy();
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		if (hresp !== 1'b0) fail("error response");
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		cmp(q, e, m);
	endtask

	task automatic tbl(input logic w, input logic hi, input logic [15:0] wd);
		i_core_model.access(w, hi, bm, pg, ea, wd, rd, ok);
		if (ok !== 1'b1) begin
			fail("table timeout");
			wrap_up();
		end
	endtask

	task automatic key(input logic [7:0] k);
		wr(OFS_KEY, {24'h00_0000, k});
	endtask

	// Setup write, key pair, then the start write
	task automatic go(input logic [15:0] c);
		nstall = 0;
		nprog = 0;
		nerase = 0;
		wr(OFS_CONTROL, {16'h0000, c & 16'h7FFF});
		key(KEY_FIRST);
		key(KEY_SECOND);
		wr(OFS_CONTROL, {16'h0000, c | 16'h8000});
		repeat (2) @(posedge clk);
	endtask

	task automatic idle(input int e);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_stall === 1'b1 && n < 1000);
		if (n >= 1000) begin
			fail("stall timeout");
			wrap_up();
		end
		cmp(nstall, e, "stall length");
	endtask

	always @(posedge clk) begin
		if (cpu_stall === 1'b1) nstall++;
		if (array_cmd.erase === 1'b1) begin
			nerase++;
			cmp(array_cmd.addr, exp_row, "erase row");
		end
		if (array_cmd.prog_we === 1'b1) begin
			cmp(array_cmd.addr, {exp_row[23:6], nprog[4:0], 1'b0},
				"prog addr");
			cmp(array_cmd.data, lat[nprog[4:0]], "prog data");
			nprog++;
		end
		if (tbl_rsp.done === 1'b1 && cpu_stall === 1'b1) fail("table busy");
	end

	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (offs[i]) rc(offs[i], 32'h0000_0000, "reset value");
		go(16'h0041);
		idle(0);
		wr(OFS_CONTROL, 32'h0000_4041);
		key(KEY_FIRST);
		key(8'h12);
		key(KEY_SECOND);
		wr(OFS_CONTROL, 32'h0000_C041);
		idle(0);
		key(KEY_FIRST);
		key(KEY_SECOND);
		wr(OFS_ADDR_LOW, 32'h0000_0000);
		wr(OFS_CONTROL, 32'h0000_C041);
		idle(0);
		rc(OFS_CONTROL, 32'h0000_4041, "refused start");
		r = $random(seed);
		pg = r[7:0];
		base = r[31:16] & 16'hFFC0;
		// Latches filled in order from a row boundary
		for (int i = 0; i < 32; i++) begin
			r = $random(seed);
			lat[i] = r[23:0];
			ea = base + 16'(2 * i);
			tbl(1'b1, 1'b0, lat[i][15:0]);
			tbl(1'b1, 1'b1, {r[31:24], lat[i][23:16]});
		end
		rc(OFS_ADDR_LOW, {16'h0000, base + 16'd62}, "low capture");
		rc(OFS_ADDR_UP, {24'h00_0000, pg}, "upper capture");
		for (int k = 0; k < 3; k++) begin
			r = $random(seed);
			pg = r[7:0];
			ea = r[23:8];
			x = img({pg, ea});
			tbl(1'b0, 1'b0, 16'h0000);
			cmp(rd, x[15:0], "load low");
			tbl(1'b0, 1'b1, 16'h0000);
			cmp(rd, {8'h00, x[23:16]}, "load high");
			bm = 1'b1;
			tbl(1'b0, 1'b0, 16'h0000);
			cmp(rd, {8'h00, ea[0] ? x[15:8] : x[7:0]}, "byte low");
			tbl(1'b0, 1'b1, 16'h0000);
			cmp(rd, ea[0] ? 16'h0000 : {8'h00, x[23:16]}, "byte high");
			bm = 1'b0;
		end
		pg = lat[3][7:0] ^ lat[5][7:0];
		wr(OFS_ADDR_LOW, {16'h0000, base});
		wr(OFS_ADDR_UP, {24'h00_0000, pg});
		rc(OFS_ADDR_LOW, {16'h0000, base}, "direct low");
		rc(OFS_ADDR_UP, {24'h00_0000, pg}, "direct upper");
		exp_row = {pg, base};
		go(16'h4001);
		idle(OPC);
		cmp(nprog, 32, "prog count");
		rc(OFS_CONTROL, 32'h0000_4001, "start cleared");
		rc(OFS_STATUS, 32'h0000_0001, "done set");
		wr(OFS_STATUS, 32'h0000_0001);
		rc(OFS_STATUS, 32'h0000_0000, "done cleared");
		r = $random(seed);
		pg = r[7:0];
		base = r[31:16] & 16'hFFC0;
		ea = base;
		wr(OFS_ADDR_LOW, {16'h0000, base});
		wr(OFS_ADDR_UP, {24'h00_0000, pg});
		exp_row = {pg, base};
		// Row update: read the row into an image and change one word
		for (int i = 0; i < 32; i++) begin
			ea = base + 16'(2 * i);
			tbl(1'b0, 1'b0, 16'h0000);
			lat[i][15:0] = rd;
			tbl(1'b0, 1'b1, 16'h0000);
			lat[i][23:16] = rd[7:0];
		end
		lat[9] = ~lat[9];
		ea = base;
		go(16'h4041);
		fork
			tbl(1'b1, 1'b0, 16'h1234);
		join_none
		wr(OFS_CONTROL, 32'h0000_0000);
		idle(OPC);
		wait fork;
		cmp(nerase, 1, "erase count");
		// Reload every latch from the changed image, then program the row
		for (int i = 0; i < 32; i++) begin
			ea = base + 16'(2 * i);
			tbl(1'b1, 1'b0, lat[i][15:0]);
			tbl(1'b1, 1'b1, {8'h00, lat[i][23:16]});
		end
		go(16'h4001);
		idle(OPC);
		cmp(nprog, 32, "reprogram count");
		// Abort in mid erase keeps settings and flags the error
		go(16'h4041);
		repeat (8) @(posedge clk);
		warm_reset <= 1'b1;
		@(posedge clk);
		warm_reset <= 1'b0;
		rc(OFS_CONTROL, 32'h0000_6041, "abort error");
		rc(OFS_ADDR_LOW, {16'h0000, base + 16'd62}, "addr kept");
		cmp(cpu_stall, 1'b0, "stall after abort");
		wrap_up();
	end
endmodule
`default_nettype wire
